// ==== sac_pkg.sv ====
// Shared constants for the step attenuator control link
package sac_pkg;
  localparam int unsigned CODE_W    = 6;
  localparam logic [5:0]  ATTEN_MAX = 6'h3f;   // Power-up code, full attenuation
  localparam logic [5:0]  ATTEN_MIN = 6'h00;
  localparam int unsigned CLK_MHZ   = 250;
  // Least times in ns, with cycle counts rounded up
  localparam int unsigned T_SETUP_NS   = 10;
  localparam int unsigned T_MODE_NS    = 100;
  localparam int unsigned T_LEW_NS     = 30;
  localparam int unsigned SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MODE_CYC     = (T_MODE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LEW_CYC      = (T_LEW_NS * CLK_MHZ + 999) / 1000;
  // Controller Wishbone register offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;  // [0] start, [1] parallel mode, [2] latched
  localparam logic [3:0]  REG_CODE   = 4'h4;  // [5:0] code to send
  localparam logic [3:0]  REG_STATUS = 4'h8;  // [0] busy
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_PAR   = 1;
  localparam int unsigned CTRL_LATCH = 2;
  localparam int unsigned HALF_CYC   = 6;       // Serial clock half period, less one, in clk cycles
endpackage

// ==== sac_link_if.sv ====
// Pin-level link between attenuator device and its controller
`timescale 1ns/1ns
`default_nettype none
interface sac_link_if;
  logic       interface_select_pin;  // High serial, low parallel
  logic       latch_strobe;
  logic       ser_clk;
  logic       ser_data;
  logic [5:0] par_code;              // [5] atten_bit_16db ... [0] atten_bit_half_db
  modport device (input interface_select_pin, input latch_strobe, input ser_clk,
                  input ser_data, input par_code);
  modport ctrl   (output interface_select_pin, output latch_strobe, output ser_clk,
                  output ser_data, output par_code);
endinterface
`default_nettype wire

// ==== sac_device.sv ====
// Attenuator control logic: serial shift register, latch and parallel modes
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Mode pin high serial, low parallel
// - Six-stage shift register, MSB sent first
// - Parallel pins held low in serial
// - Binary weighted code, 16 dB top bit
// - Strobe rising edge loads shift register
// - Data captured on serial clock rise
// - Strobe high disables shifting
// - Controller keeps strobe high when idle
// - Power-up code is maximum attenuation
// - Direct parallel follows pins immediately
// - Latched parallel ignores pins strobe low
// - Strobe low, set pins, raise strobe
// - Parallel strobe-low start stays maximum
module sac_device
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  sac_link_if.device      link,
  output logic [5:0]      atten_code_o,   // Bit weights 16,8,4,2,1,0.5 dB
  output logic [8:0]      atten_half_db_o // Attenuation in 0.5 dB units
);
  logic [1:0] mode_s;
  logic [1:0] le_s;
  logic [1:0] sck_s;
  logic [1:0] sda_s;
  logic [5:0] par_s0;
  logic [5:0] par_s1;
  logic       le_d;
  logic       sck_d;
  logic [5:0] shift_reg;
  logic       le_rise;
  logic       sck_rise;

  // Two-stage synchronisers on every pin
  always_ff @(posedge clk_i)
  begin
    mode_s <= {mode_s[0], link.interface_select_pin};
    le_s   <= {le_s[0], link.latch_strobe};
    sck_s  <= {sck_s[0], link.ser_clk};
    sda_s  <= {sda_s[0], link.ser_data};
    par_s0 <= link.par_code;
    par_s1 <= par_s0;
  end

  // Edge history on synchronised levels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      le_d  <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      le_d  <= le_s[1];
      sck_d <= sck_s[1];
    end
  end

  assign le_rise  = le_s[1] & ~le_d;
  assign sck_rise = sck_s[1] & ~sck_d;

  // Shift register, MSB enters first and moves up
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shift_reg <= sac_pkg::ATTEN_MAX;
    else if (mode_s[1] && sck_rise && !le_s[1])
      shift_reg <= {shift_reg[4:0], sda_s[1]};
  end

  // Active attenuation setting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      atten_code_o <= sac_pkg::ATTEN_MAX;
    else if (mode_s[1])
    begin
      if (le_rise)
        atten_code_o <= shift_reg;
    end
    else if (le_s[1])
      atten_code_o <= par_s1;
  end

  // Attenuation in half-dB steps equals the binary code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      atten_half_db_o <= {3'h0, sac_pkg::ATTEN_MAX};
    else if (mode_s[1])
    begin
      if (le_rise)
        atten_half_db_o <= {3'h0, shift_reg};
    end
    else if (le_s[1])
      atten_half_db_o <= {3'h0, par_s1};
  end
endmodule
`default_nettype wire

// ==== sac_ctrl.sv ====
// Wishbone-driven controller that programs the attenuator pins
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  sac_link_if.ctrl         link
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_CLKLO = 5'b00100,
    ST_CLKHI = 5'b01000,
    ST_LATCH = 5'b10000
  } sac_state_e;

  sac_state_e state;
  logic [2:0] ctrl;
  logic [5:0] code;
  logic [2:0] bit_cnt;
  logic [7:0] tmr;
  logic       wr;
  logic       start;

  assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign start = wr && wb_adr_i == sac_pkg::REG_CTRL && wb_dat_i[sac_pkg::CTRL_START]
                 && state == ST_IDLE;

  // Bus ack, one cycle after request, read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i)
        sac_pkg::REG_CTRL:   wb_dat_o <= {29'h0, ctrl};
        sac_pkg::REG_CODE:   wb_dat_o <= {26'h0, code};
        sac_pkg::REG_STATUS: wb_dat_o <= {31'h0, state != ST_IDLE};
        default:             wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Control and code registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= 3'h0;
      code <= sac_pkg::ATTEN_MAX;
    end
    else if (wr && state == ST_IDLE)
    begin
      if (wb_adr_i == sac_pkg::REG_CTRL)
        ctrl <= {wb_dat_i[2:1], 1'b0};
      if (wb_adr_i == sac_pkg::REG_CODE)
        code <= wb_dat_i[5:0];
    end
  end

  // Pin sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                     <= ST_IDLE;
      bit_cnt                   <= 3'h0;
      tmr                       <= 8'h0;
      link.interface_select_pin <= 1'b1;
      link.latch_strobe         <= 1'b1;
      link.ser_clk              <= 1'b0;
      link.ser_data             <= 1'b0;
      link.par_code             <= 6'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          if (start)
          begin
            link.interface_select_pin <= ~wb_dat_i[sac_pkg::CTRL_PAR];
            tmr     <= 8'(sac_pkg::MODE_CYC);
            bit_cnt <= 3'h0;
            if (wb_dat_i[sac_pkg::CTRL_PAR])
            begin
              link.par_code     <= code;
              link.latch_strobe <= ~wb_dat_i[sac_pkg::CTRL_LATCH];
            end
            else
            begin
              link.par_code     <= 6'h0;
              link.latch_strobe <= 1'b0;
            end
            state <= ST_SETUP;
          end
        ST_SETUP:
          if (tmr != 8'h0)
            tmr <= tmr - 8'h1;
          else if (!link.interface_select_pin)
          begin
            tmr               <= 8'(sac_pkg::LEW_CYC);
            link.latch_strobe <= 1'b1;
            state             <= ST_LATCH;
          end
          else
          begin
            link.ser_data <= code[3'h5 - bit_cnt];
            tmr           <= 8'(sac_pkg::HALF_CYC);
            state         <= ST_CLKLO;
          end
        ST_CLKLO:
          if (tmr != 8'h0)
            tmr <= tmr - 8'h1;
          else
          begin
            link.ser_clk <= 1'b1;
            tmr          <= 8'(sac_pkg::HALF_CYC);
            state        <= ST_CLKHI;
          end
        ST_CLKHI:
          if (tmr != 8'h0)
            tmr <= tmr - 8'h1;
          else
          begin
            link.ser_clk <= 1'b0;
            tmr          <= 8'(sac_pkg::HALF_CYC);
            if (bit_cnt == 3'h5)
            begin
              link.latch_strobe <= 1'b1;
              state             <= ST_LATCH;
            end
            else
            begin
              bit_cnt       <= bit_cnt + 3'h1;
              link.ser_data <= code[3'h4 - bit_cnt];
              state         <= ST_CLKLO;
            end
          end
        ST_LATCH:
          if (tmr != 8'h0)
            tmr <= tmr - 8'h1;
          else
          begin
            link.interface_select_pin <= 1'b1;
            link.par_code             <= 6'h0;
            state                     <= ST_IDLE;
          end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== sac_link_monitor.sv ====
// Checker for the attenuator link pins and the active code
`timescale 1ns/1ns
`default_nettype none
module sac_link_monitor
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       interface_select_pin,
  input  wire logic       latch_strobe,
  input  wire logic       ser_clk,
  input  wire logic       ser_data,
  input  wire logic [5:0] par_code,
  input  wire logic [5:0] atten_code_o
);
  logic [5:0] shadow;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Mirror of the device shift register, MSB enters first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shadow <= 6'h00;
    else if ($rose(ser_clk) && !latch_strobe)
      shadow <= {shadow[4:0], ser_data};
  end
  sequence s_ser_load;
    $rose(latch_strobe) && interface_select_pin;
  endsequence
  sequence s_par_load;
    $rose(latch_strobe) && !interface_select_pin;
  endsequence
  a_reset_max_code: assert property ($fell(rst_i) |-> atten_code_o == 6'h3f)
    else $error("Code not at maximum after reset");
  a_shift_strobe_low: assert property ($rose(ser_clk) |-> !latch_strobe)
    else $error("Serial clock rose with strobe high");
  a_par_pins_low: assert property (interface_select_pin && !latch_strobe |-> par_code == 6'h00)
    else $error("Parallel pins not low in serial frame");
  a_data_stable: assert property ($rose(ser_clk) |-> $stable(ser_data) ##1 $stable(ser_data))
    else $error("Serial data moved around clock rise");
  a_code_held_low: assert property (!latch_strobe [*7] |-> $stable(atten_code_o))
    else $error("Code changed while strobe low");
  a_serial_load: assert property (s_ser_load |-> ##[1:8] atten_code_o == shadow)
    else $error("Strobe rise did not load shifted bits");
  a_latched_load: assert property (s_par_load |-> ##[1:8] atten_code_o == par_code)
    else $error("Strobe rise did not load parallel pins");
  a_direct_follow: assert property
    ((!interface_select_pin && latch_strobe && $stable(par_code)) [*8] |-> atten_code_o == par_code)
    else $error("Direct mode code does not follow pins");
  a_strobe_hold: assert property ($rose(latch_strobe) |-> latch_strobe [*8])
    else $error("Strobe dropped too soon");
endmodule
`default_nettype wire

// ==== step_attenuator_control_interface_test.sv ====
// Testbench joining controller and device over the link
`timescale 1ns/1ns
`default_nettype none
module step_attenuator_control_interface_test;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [31:0] wdat;
  logic [3:0]  sel;
  logic [31:0] rdat;
  logic        ack;
  logic [5:0]  code;
  logic [8:0]  half_db;
  logic [31:0] q;
  int          fail_count;
  int          checks;
  int          cycles;
  sac_link_if sac_link_if_inst ();
  sac_device sac_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(sac_link_if_inst.device),
    .atten_code_o(code), .atten_half_db_o(half_db));
  sac_ctrl sac_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link(sac_link_if_inst.ctrl));
  sac_link_monitor sac_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .interface_select_pin(sac_link_if_inst.interface_select_pin),
    .latch_strobe(sac_link_if_inst.latch_strobe), .ser_clk(sac_link_if_inst.ser_clk),
    .ser_data(sac_link_if_inst.ser_data), .par_code(sac_link_if_inst.par_code),
    .atten_code_o(code));
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Cycle ceiling against hangs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  task summarize();
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // One classic Wishbone cycle, read data left in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the cycle ceiling ends a wait for ack
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic idle();
    do
      wb(1'b0, sac_pkg::REG_STATUS, 32'h0);
    while (q[0] !== 1'b0);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic run(input logic [5:0] c, input logic [31:0] ctl);
    wb(1'b1, sac_pkg::REG_CODE, 32'(c));
    wb(1'b1, sac_pkg::REG_CTRL, ctl);
    idle();
    chk("atten_code", 32'(code), 32'(c));
    chk("half_db", 32'(half_db), 32'(c));
  endtask
  task t_power_up();
    chk("atten_code", 32'(code), 32'h3f);
    wb(1'b0, sac_pkg::REG_CODE, 32'h0);
    chk("code_reg", q, 32'h3f);
    wb(1'b1, sac_pkg::REG_CODE, 32'h11, 4'h0);
    wb(1'b0, sac_pkg::REG_CODE, 32'h0);
    chk("code_sel_off", q, 32'h3f);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task t_serial_weights();
    logic [5:0] w [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h27, 6'h00};
    foreach (w[i]) run(w[i], 32'h1);
  endtask
  task t_busy_refuse();
    wb(1'b1, sac_pkg::REG_CODE, 32'h15);
    wb(1'b1, sac_pkg::REG_CTRL, 32'h1);
    wb(1'b0, sac_pkg::REG_STATUS, 32'h0);
    chk("busy", q, 32'h1);
    wb(1'b1, sac_pkg::REG_CODE, 32'h2a);
    wb(1'b0, sac_pkg::REG_CODE, 32'h0);
    chk("code_reg", q, 32'h15);
    idle();
    chk("atten_code", 32'(code), 32'h15);
  endtask
  task automatic t_latched();
    wb(1'b1, sac_pkg::REG_CODE, 32'h33);
    wb(1'b1, sac_pkg::REG_CTRL, 32'h7);
    while (sac_link_if_inst.latch_strobe !== 1'b0)
      @(posedge clk_i);
    repeat (10) @(posedge clk_i);
    chk("atten_code", 32'(code), 32'h0c);
    idle();
    chk("atten_code", 32'(code), 32'h33);
    wb(1'b0, sac_pkg::REG_CTRL, 32'h0);
    chk("ctrl_reg", q, 32'h6);
  endtask
  // Reset, then the scenarios
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, sel} = '0;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_power_up();
    t_serial_weights();
    t_busy_refuse();
    run(6'h0c, 32'h3);
    t_latched();
    run(6'h2a, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
